// *** verilog/rsc_top.sv ***
// Reset, enable, fallback and supply monitor control with AXI4-Lite registers
// What this block does
// - A reset line held low by the partner for the filter time starts a reset.
// - Every internally started reset except Overtemp entry drives a low pulse onto the reset line.
// - Pulse length is selectable only for undervoltage, Off exit and Overtemp exit.
// - Selectable causes give short pulse with strap resistor, long without.
// - All other internal causes, watchdog ones included, give the short pulse; Overtemp entry holds the line low instead.
// - Enable output high only with its control bit set and mode 10 or 11.
// - Enable control bit is writable in Normal and Standby modes.
// - Any reset event forces the enable output low.
// - Fallback output is active low open drain.
// - Every system reset sets the fallback warning flag.
// - Reset with warning already set sets fallback active, driving the output low.
// - Overtemp mode holds the fallback active flag set.
// - Software may clear the fallback active flag to release the output.
// - Power-off detection enters Off mode at once, regulators and logic down.
// - Battery above power-on threshold leaves Off mode for Standby.
// - Leaving Off mode sets the power-on flag.
// - Split control bit selects 85 mA at 0 or 50 mA at 1.
// - Main regulator undervoltage resets; threshold select picks 90 or 70 percent.
// - Main supply warning flag sets at 90 percent regardless of threshold select.
// - Main supply status bit shows the live main regulator state.
// - Mode field switches the bus regulator; value 10 turns it off.
// - Bus supply warning flag sets when bus regulator drops below 90 percent.
// - Bus supply status is live only in Normal mode, else reads 1.
// - Interrupt status flags clear on a write of 1.
`timescale 1ns/1ps
`include "rsc_consts.svh"
module rsc_top #(
    parameter int FILTER_CYC = `RSC_FILTER_CYC,
    parameter int SHORT_CYC = `RSC_SHORT_CYC,
    parameter int LONG_CYC = `RSC_LONG_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire rsc_pkg::rsc_axi_req_s axi_req,
    output rsc_pkg::rsc_axi_rsp_s axi_rsp,
    input wire logic system_reset_line_in,
    output logic system_reset_line_out,
    output logic system_reset_line_oe,
    input wire logic strap_short_present,
    input wire logic main_power_in_poff,
    input wire logic main_power_in_pon,
    input wire logic overtemp_hot,
    input wire logic other_reset_req,
    input wire rsc_pkg::rsc_supply_s supply,
    output logic enable_out,
    output logic fallback_out,
    output logic fallback_oe,
    output logic main_regulator_en,
    output logic bus_regulator_en,
    output logic dissipation_split_out,
    output logic undervolt_threshold_out
);
    // Normal mode is either of the two upper mode codes
    function automatic logic is_normal(input logic [1:0] m);
        is_normal = m[1];
    endfunction

    rsc_pkg::rsc_dev_e dev_ff;
    logic [1:0] mode_ctrl_field_ff;
    logic enable_output_ctrl_ff;
    logic fallback_warning_flag_ff;
    logic fallback_active_flag_ff;
    logic dissipation_split_ctrl_ff;
    logic undervolt_threshold_sel_ff;
    logic power_on_flag_ff;
    logic main_supply_warn_irq_ff;
    logic bus_supply_warn_irq_ff;
    logic strap_ff;
    logic strap_taken_ff;
    logic [15:0] pulse_cnt_ff;
    logic [15:0] filt_cnt_ff;
    logic main_uv_prev_ff;
    logic main_warn_prev_ff;
    logic bus_warn_prev_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic wstrb0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    logic running;
    logic driving;
    logic main_uv;
    logic main_uv_rise;
    logic leave_off;
    logic leave_hot;
    logic enter_hot;
    logic ext_rst_ev;
    logic sel_rst_ev;
    logic fix_rst_ev;
    logic sys_rst_ev;
    logic [15:0] sel_len;
    logic wr_fire;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_mc;
    logic wr_ic;
    logic wr_is;
    logic ar_fire;
    logic [31:0] status_word;

    // Event decode
    assign running = (dev_ff == rsc_pkg::RSC_DEV_RUN);
    assign main_uv = undervolt_threshold_sel_ff ? supply.main_below_70 : supply.main_below_90;
    assign main_uv_rise = running & main_uv & ~main_uv_prev_ff;
    assign leave_off = (dev_ff == rsc_pkg::RSC_DEV_OFF) & main_power_in_pon & ~main_power_in_poff;
    assign leave_hot = (dev_ff == rsc_pkg::RSC_DEV_OVERTEMP) & ~overtemp_hot & ~main_power_in_poff;
    assign enter_hot = running & overtemp_hot & (mode_ctrl_field_ff != 2'h1) & ~main_power_in_poff;
    assign sel_rst_ev = main_uv_rise | leave_off | leave_hot;
    assign fix_rst_ev = running & other_reset_req;
    assign ext_rst_ev = running & ~driving & ~system_reset_line_in
        & (filt_cnt_ff == 16'(FILTER_CYC - 1));
    assign sys_rst_ev = sel_rst_ev | fix_rst_ev | ext_rst_ev | enter_hot;
    assign sel_len = strap_ff ? 16'(SHORT_CYC) : 16'(LONG_CYC);

    // Strap caught on the first clock after reset release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_taken_ff <= 1'b0;
            strap_ff <= 1'b0;
        end else if (!strap_taken_ff) begin
            strap_taken_ff <= 1'b1;
            strap_ff <= strap_short_present;
        end
    end

    // Device state: off, running, overtemp
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dev_ff <= rsc_pkg::RSC_DEV_OFF;
        end else if (main_power_in_poff) begin
            dev_ff <= rsc_pkg::RSC_DEV_OFF;
        end else begin
            case (dev_ff)
                rsc_pkg::RSC_DEV_OFF: begin
                    if (leave_off) begin
                        dev_ff <= rsc_pkg::RSC_DEV_RUN;
                    end
                end
                rsc_pkg::RSC_DEV_RUN: begin
                    if (enter_hot) begin
                        dev_ff <= rsc_pkg::RSC_DEV_OVERTEMP;
                    end
                end
                rsc_pkg::RSC_DEV_OVERTEMP: begin
                    if (leave_hot) begin
                        dev_ff <= rsc_pkg::RSC_DEV_RUN;
                    end
                end
                default: begin
                    dev_ff <= rsc_pkg::RSC_DEV_OFF;
                end
            endcase
        end
    end

    // Edge history of the supply comparators
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_uv_prev_ff <= 1'b0;
            main_warn_prev_ff <= 1'b0;
            bus_warn_prev_ff <= 1'b0;
        end else begin
            main_uv_prev_ff <= main_uv;
            main_warn_prev_ff <= supply.main_below_90;
            bus_warn_prev_ff <= supply.bus_below_90;
        end
    end

    // Low-level filter on the reset line, blind while we drive it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_cnt_ff <= 16'h0000;
        end else if (driving || system_reset_line_in || !running) begin
            filt_cnt_ff <= 16'h0000;
        end else if (filt_cnt_ff != 16'(FILTER_CYC)) begin
            filt_cnt_ff <= filt_cnt_ff + 16'h0001;
        end
    end

    // Reset pulse length counter
    always_ff @(posedge aclk) begin
        if (!aresetn || main_power_in_poff) begin
            pulse_cnt_ff <= 16'h0000;
        end else if (sel_rst_ev || (running && main_uv)) begin
            pulse_cnt_ff <= sel_len;
        end else if (fix_rst_ev) begin
            pulse_cnt_ff <= 16'(SHORT_CYC);
        end else if (pulse_cnt_ff != 16'h0000) begin
            pulse_cnt_ff <= pulse_cnt_ff - 16'h0001;
        end
    end

    // Reset line driven low during pulse and throughout Overtemp
    assign driving = (pulse_cnt_ff != 16'h0000) | (dev_ff == rsc_pkg::RSC_DEV_OVERTEMP);
    assign system_reset_line_out = 1'b0;
    assign system_reset_line_oe = driving;

    // AXI write channel capture, address and data in either order
    assign wr_fire = (aw_got_ff | axi_req.awvalid) & (w_got_ff | axi_req.wvalid) & ~bvalid_ff;
    assign wr_addr = aw_got_ff ? awaddr_ff : axi_req.awaddr;
    assign wr_data = w_got_ff ? wdata_ff : axi_req.wdata;
    assign wr_mc = wr_fire & (wr_addr == `RSC_OFF_MODE_CTRL) & (w_got_ff ? wstrb0_ff : axi_req.wstrb[0]);
    assign wr_ic = wr_fire & (wr_addr == `RSC_OFF_INT_CTRL) & (w_got_ff ? wstrb0_ff : axi_req.wstrb[0]);
    assign wr_is = wr_fire & (wr_addr == `RSC_OFF_INT_STATUS) & (w_got_ff ? wstrb0_ff : axi_req.wstrb[0]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb0_ff <= 1'b0;
        end else if (wr_fire) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
        end else begin
            if (axi_req.awvalid && !aw_got_ff) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= axi_req.awaddr;
            end
            if (axi_req.wvalid && !w_got_ff) begin
                w_got_ff <= 1'b1;
                wdata_ff <= axi_req.wdata;
                wstrb0_ff <= axi_req.wstrb[0];
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `RSC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (wr_addr[7:4] == 4'h0 && wr_addr[1:0] == 2'h0) ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
        end else if (axi_req.bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Mode field and enable control
    always_ff @(posedge aclk) begin
        if (!aresetn || dev_ff == rsc_pkg::RSC_DEV_OFF) begin
            mode_ctrl_field_ff <= `RSC_MODE_RST;
            enable_output_ctrl_ff <= 1'b0;
        end else if (sys_rst_ev || dev_ff == rsc_pkg::RSC_DEV_OVERTEMP) begin
            enable_output_ctrl_ff <= 1'b0;
            if (leave_hot) begin
                mode_ctrl_field_ff <= `RSC_MODE_RST;
            end
        end else if (wr_mc && running) begin
            mode_ctrl_field_ff <= wr_data[`RSC_MC_MODE_LO+1:`RSC_MC_MODE_LO];
            if (mode_ctrl_field_ff != 2'h1) begin
                enable_output_ctrl_ff <= wr_data[`RSC_MC_ENC];
            end
        end
    end

    // Fallback warning and active flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fallback_warning_flag_ff <= 1'b0;
            fallback_active_flag_ff <= 1'b0;
        end else if (dev_ff == rsc_pkg::RSC_DEV_OFF) begin
            // Off exit is itself a system reset, so it leaves the warning set
            fallback_warning_flag_ff <= leave_off;
            fallback_active_flag_ff <= 1'b0;
        end else if (sys_rst_ev || dev_ff == rsc_pkg::RSC_DEV_OVERTEMP) begin
            fallback_warning_flag_ff <= fallback_warning_flag_ff | sys_rst_ev;
            if (fallback_warning_flag_ff || dev_ff == rsc_pkg::RSC_DEV_OVERTEMP || enter_hot) begin
                fallback_active_flag_ff <= 1'b1;
            end
        end else if (wr_mc) begin
            fallback_warning_flag_ff <= wr_data[`RSC_MC_WARN];
            fallback_active_flag_ff <= fallback_active_flag_ff & wr_data[`RSC_MC_ACTIVE];
        end
    end

    // Split and threshold selects
    always_ff @(posedge aclk) begin
        if (!aresetn || dev_ff == rsc_pkg::RSC_DEV_OFF) begin
            dissipation_split_ctrl_ff <= 1'b0;
            undervolt_threshold_sel_ff <= 1'b0;
        end else begin
            if (wr_mc) begin
                dissipation_split_ctrl_ff <= wr_data[`RSC_MC_SPLIT];
            end
            if (wr_ic) begin
                undervolt_threshold_sel_ff <= wr_data[`RSC_IC_THRESH];
            end
        end
    end

    // Interrupt status flags, set wins over write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_on_flag_ff <= `RSC_PON_RST;
            main_supply_warn_irq_ff <= 1'b0;
            bus_supply_warn_irq_ff <= 1'b0;
        end else if (dev_ff == rsc_pkg::RSC_DEV_OFF) begin
            power_on_flag_ff <= power_on_flag_ff | leave_off;
            main_supply_warn_irq_ff <= 1'b0;
            bus_supply_warn_irq_ff <= 1'b0;
        end else begin
            power_on_flag_ff <= power_on_flag_ff & ~(wr_is & wr_data[`RSC_IS_PON]);
            main_supply_warn_irq_ff <= (main_supply_warn_irq_ff & ~(wr_is & wr_data[`RSC_IS_MAIN_WARN]))
                | (supply.main_below_90 & ~main_warn_prev_ff);
            bus_supply_warn_irq_ff <= (bus_supply_warn_irq_ff & ~(wr_is & wr_data[`RSC_IS_BUS_WARN]))
                | (bus_regulator_en & supply.bus_below_90 & ~bus_warn_prev_ff);
        end
    end

    // Status word
    always_comb begin
        status_word = 32'h00000000;
        status_word[`RSC_ST_MAIN] = ~supply.main_below_90;
        status_word[`RSC_ST_BUS] = is_normal(mode_ctrl_field_ff) && running ? ~supply.bus_below_90 : 1'b1;
        status_word[`RSC_ST_DRIVING] = driving;
        status_word[`RSC_ST_STRAP] = strap_ff;
        status_word[`RSC_ST_STATE_LO+1:`RSC_ST_STATE_LO] = dev_ff;
    end

    // AXI read channel
    assign ar_fire = axi_req.arvalid & ~rvalid_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `RSC_RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= `RSC_RESP_OKAY;
            case (axi_req.araddr)
                `RSC_OFF_MODE_CTRL: begin
                    rdata_ff <= {26'h0, dissipation_split_ctrl_ff, fallback_active_flag_ff,
                        fallback_warning_flag_ff, enable_output_ctrl_ff, mode_ctrl_field_ff};
                end
                `RSC_OFF_INT_CTRL: begin
                    rdata_ff <= {31'h0, undervolt_threshold_sel_ff};
                end
                `RSC_OFF_INT_STATUS: begin
                    rdata_ff <= {29'h0, bus_supply_warn_irq_ff, main_supply_warn_irq_ff, power_on_flag_ff};
                end
                `RSC_OFF_STATUS: begin
                    rdata_ff <= status_word;
                end
                default: begin
                    rdata_ff <= 32'h00000000;
                    rresp_ff <= `RSC_RESP_SLVERR;
                end
            endcase
        end else if (axi_req.rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Bus answers
    always_comb begin
        axi_rsp.awready = ~aw_got_ff & ~bvalid_ff;
        axi_rsp.wready = ~w_got_ff & ~bvalid_ff;
        axi_rsp.bvalid = bvalid_ff;
        axi_rsp.bresp = bresp_ff;
        axi_rsp.arready = ~rvalid_ff;
        axi_rsp.rvalid = rvalid_ff;
        axi_rsp.rdata = rdata_ff;
        axi_rsp.rresp = rresp_ff;
    end

    // Pin and analog control outputs
    assign enable_out = enable_output_ctrl_ff & is_normal(mode_ctrl_field_ff) & running & ~driving;
    assign fallback_out = 1'b0;
    assign fallback_oe = fallback_active_flag_ff;
    assign main_regulator_en = running & (mode_ctrl_field_ff != 2'h1);
    assign bus_regulator_en = running & (mode_ctrl_field_ff != 2'h2);
    assign dissipation_split_out = dissipation_split_ctrl_ff;
    assign undervolt_threshold_out = undervolt_threshold_sel_ff;
endmodule

// *** verilog/rsc_consts.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH
`define RSC_OFF_MODE_CTRL 8'h00
`define RSC_OFF_INT_CTRL 8'h04
`define RSC_OFF_INT_STATUS 8'h08
`define RSC_OFF_STATUS 8'h0C
`define RSC_MC_MODE_LO 0
`define RSC_MC_ENC 2
`define RSC_MC_WARN 3
`define RSC_MC_ACTIVE 4
`define RSC_MC_SPLIT 5
`define RSC_IC_THRESH 0
`define RSC_IS_PON 0
`define RSC_IS_MAIN_WARN 1
`define RSC_IS_BUS_WARN 2
`define RSC_ST_MAIN 0
`define RSC_ST_BUS 1
`define RSC_ST_DRIVING 2
`define RSC_ST_STRAP 3
`define RSC_ST_STATE_LO 4
`define RSC_MODE_RST 2'h0
`define RSC_PON_RST 1'b1
`define RSC_FILTER_CYC 16
`define RSC_SHORT_CYC 64
`define RSC_LONG_CYC 256
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2
`endif

// *** verilog/rsc_pkg.sv ***
// Types shared by the reset and supply control block
package rsc_pkg;
    typedef enum logic [1:0] {
        RSC_DEV_OFF = 2'b00,
        RSC_DEV_RUN = 2'b01,
        RSC_DEV_OVERTEMP = 2'b10
    } rsc_dev_e;
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } rsc_axi_req_s;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rsc_axi_rsp_s;
    typedef struct packed {
        logic main_below_90;
        logic main_below_70;
        logic bus_below_90;
    } rsc_supply_s;
endpackage

// *** sim/rsc_top_chk.sv ***
// Port-level assertions for the reset and supply control block
`timescale 1ns/1ps
module rsc_top_chk #(
    parameter int FILTER_CYC = 16,
    parameter int SHORT_CYC = 64
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire rsc_pkg::rsc_axi_req_s axi_req,
    input wire logic system_reset_line_in,
    input wire logic system_reset_line_out,
    input wire logic system_reset_line_oe,
    input wire logic main_power_in_poff,
    input wire logic enable_out,
    input wire logic fallback_out,
    input wire logic main_regulator_en,
    input wire logic bus_regulator_en
);
    int low_cnt_ff;
    int oe_len_ff;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Consecutive low samples of the reset line
    always_ff @(posedge aclk) begin
        if (!aresetn || system_reset_line_in) begin
            low_cnt_ff <= 0;
        end else if (low_cnt_ff <= FILTER_CYC) begin
            low_cnt_ff <= low_cnt_ff + 1;
        end
    end
    // Length of the pulse being driven
    always_ff @(posedge aclk) begin
        if (!aresetn || !system_reset_line_oe) begin
            oe_len_ff <= 0;
        end else begin
            oe_len_ff <= oe_len_ff + 1;
        end
    end
    sequence s_line_held;
        low_cnt_ff == FILTER_CYC;
    endsequence
    sequence s_pulse_end;
        $fell(system_reset_line_oe) && !$past(main_power_in_poff);
    endsequence
    a_line_drive_low: assert property (system_reset_line_oe |-> system_reset_line_out == 1'b0)
        else $error("reset line driven high");
    a_fallback_open_drain: assert property (fallback_out == 1'b0)
        else $error("fallback pin driven high");
    a_enable_reset_low: assert property (system_reset_line_oe [*2] |-> !enable_out)
        else $error("enable high in reset pulse");
    a_enable_needs_run: assert property (enable_out |-> main_regulator_en)
        else $error("enable high with regulator off");
    a_enable_by_write: assert property ($rose(enable_out) |-> $past(axi_req.wvalid) || $past(axi_req.wvalid, 2))
        else $error("enable rose without a write");
    a_filter_reset: assert property (s_line_held |-> ##[0:2] !enable_out)
        else $error("held line kept enable high");
    a_poff_shutdown: assert property (main_power_in_poff |-> ##[1:2] (!main_regulator_en && !bus_regulator_en))
        else $error("regulators on after power-off");
    a_pulse_min_len: assert property (s_pulse_end |-> oe_len_ff >= SHORT_CYC)
        else $error("reset pulse too short");
endmodule
bind rsc_top rsc_top_chk #(.FILTER_CYC(FILTER_CYC), .SHORT_CYC(SHORT_CYC)) u_chk (.aclk, .aresetn, .axi_req,
    .system_reset_line_in, .system_reset_line_out, .system_reset_line_oe, .main_power_in_poff, .enable_out,
    .fallback_out, .main_regulator_en, .bus_regulator_en);

// *** sim/rsc_mcu_model.sv ***
// Microcontroller side of the reset line with its strap resistor
`timescale 1ns/1ps
module rsc_mcu_model (
    input wire logic aclk,
    input wire logic hold_low,
    input wire logic strap_fit,
    input wire logic dut_oe,
    input wire logic dut_out,
    output logic line,
    output logic strap_short_present
);
    logic hold_ff = 1'b0;
    // Pull request taken just after an edge
    always_ff @(posedge aclk) begin
        hold_ff <= hold_low;
    end
    // Wired-AND of both pull-downs, pull-up when released
    assign line = !(hold_ff || (dut_oe && !dut_out));
    // Strap resistor seen by the detector
    assign strap_short_present = strap_fit;
endmodule

// *** sim/rsc_top_tb_top.sv ***
// Register-level bench for the reset and supply control block
`timescale 1ns/1ps
`include "rsc_consts.svh"
module rsc_top_tb_top;
    localparam int FC = 4;
    localparam int SC = 8;
    localparam int LC = 16;
    localparam logic [7:0] A_MODE = `RSC_OFF_MODE_CTRL;
    localparam logic [7:0] A_INTC = `RSC_OFF_INT_CTRL;
    localparam logic [7:0] A_INTS = `RSC_OFF_INT_STATUS;
    localparam logic [7:0] A_STAT = `RSC_OFF_STATUS;
    logic aclk, aresetn, line_in, line_out, line_oe, strap, poff, pon, hot, other, enable_out;
    logic fb_out, fb_oe, main_en, bus_en, split, thr, hold_low, strap_fit;
    rsc_pkg::rsc_axi_req_s axi_req;
    rsc_pkg::rsc_axi_rsp_s axi_rsp;
    rsc_pkg::rsc_supply_s supply;
    logic [1:0] md [3] = '{2'h0, 2'h2, 2'h3};
    logic [31:0] d;
    logic [1:0] r;
    int bad_count, cmp_count, n;
    int cyc = 0;
    rsc_top #(.FILTER_CYC(FC), .SHORT_CYC(SC), .LONG_CYC(LC)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .axi_req(axi_req), .axi_rsp(axi_rsp), .system_reset_line_in(line_in), .system_reset_line_out(line_out),
        .system_reset_line_oe(line_oe), .strap_short_present(strap), .main_power_in_poff(poff),
        .main_power_in_pon(pon), .overtemp_hot(hot), .other_reset_req(other), .supply(supply),
        .enable_out(enable_out), .fallback_out(fb_out), .fallback_oe(fb_oe), .main_regulator_en(main_en),
        .bus_regulator_en(bus_en), .dissipation_split_out(split), .undervolt_threshold_out(thr));
    rsc_mcu_model u_mcu (.aclk(aclk), .hold_low(hold_low), .strap_fit(strap_fit), .dut_oe(line_oe),
        .dut_out(line_out), .line(line_in), .strap_short_present(strap));
    // Clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // Hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            finish_test();
        end
    end
    task automatic finish_test();
        if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= v;
        do begin
            @(posedge aclk);
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (axi_rsp.bvalid !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        do begin
            @(posedge aclk);
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (axi_rsp.rvalid !== 1'b1);
        d = axi_rsp.rdata;
        r = axi_rsp.rresp;
    endtask
    task automatic pull(input int k);
        hold_low <= 1'b1;
        tick(k);
        hold_low <= 1'b0;
        tick(4);
    endtask
    task automatic plen();
        while (line_oe !== 1'b1) @(posedge aclk);
        n = 0;
        while (line_oe === 1'b1) begin
            n++;
            @(posedge aclk);
        end
    endtask
    // Main sequence
    initial begin
        axi_req = '0;
        axi_req.wstrb = 4'hF;
        axi_req.bready = 1'b1;
        axi_req.rready = 1'b1;
        supply = '0;
        {aresetn, hold_low, strap_fit, poff, pon, hot, other, bad_count, cmp_count} = '0;
        tick(5);
        aresetn <= 1'b1;
        tick(1);
        // Reset values, unmapped access, Off exit
        rd(A_INTS);
        chk("pon_rst", d[0], 1'b1);
        rd(8'h10);
        chk("unmap_resp", r, `RSC_RESP_SLVERR);
        chk("unmap_data", d, 32'h0);
        pon <= 1'b1;
        plen();
        chk("off_exit_len", n, LC);
        rd(A_STAT);
        chk("state_run", d[5:4], 2'h1);
        rd(A_MODE);
        chk("off_exit_warn", d[3], 1'b1);
        wr(A_INTS, 32'h7);
        rd(A_INTS);
        chk("ints_w1c", d[2:0], 3'h0);
        // Bus warning and mode table
        supply.bus_below_90 <= 1'b1;
        tick(2);
        rd(A_INTS);
        chk("bus_warn", d[2], 1'b1);
        foreach (md[i]) begin
            wr(A_MODE, {29'h1, md[i]});
            tick(2);
            chk("enable", enable_out, md[i][1]);
            chk("bus_reg", bus_en, md[i] != 2'h2);
            rd(A_STAT);
            chk("bus_stat", d[1], !md[i][1]);
        end
        supply.bus_below_90 <= 1'b0;
        // External reset filter and fallback
        pull(FC - 1);
        chk("glitch_en", enable_out, 1'b1);
        pull(FC + 2);
        chk("ext_en", enable_out, 1'b0);
        rd(A_MODE);
        chk("warn_set", d[4:2], 3'h2);
        pull(FC + 2);
        chk("fb_on", fb_oe, 1'b1);
        wr(A_MODE, 32'h3);
        tick(2);
        chk("fb_off", fb_oe, 1'b0);
        other <= 1'b1;
        tick(1);
        other <= 1'b0;
        plen();
        chk("other_len", n, SC);
        // Undervoltage at both thresholds
        wr(A_INTC, 32'h1);
        tick(1);
        chk("thr_out", thr, 1'b1);
        supply.main_below_90 <= 1'b1;
        tick(4);
        chk("uv90_norst", line_oe, 1'b0);
        rd(A_INTS);
        chk("main_warn", d[1], 1'b1);
        rd(A_STAT);
        chk("main_stat", d[0], 1'b0);
        supply.main_below_70 <= 1'b1;
        tick(3);
        chk("uv70_rst", line_oe, 1'b1);
        supply <= '0;
        plen();
        wr(A_INTC, 32'h0);
        supply.main_below_90 <= 1'b1;
        tick(3);
        chk("uv90_rst", line_oe, 1'b1);
        supply <= '0;
        plen();
        // Split select
        wr(A_MODE, 32'h23);
        tick(1);
        chk("split1", split, 1'b1);
        wr(A_MODE, 32'h3);
        tick(1);
        chk("split0", split, 1'b0);
        // Overtemp holds fallback, exit gives long pulse
        hot <= 1'b1;
        tick(4);
        wr(A_MODE, 32'h3);
        tick(1);
        chk("ot_fb", fb_oe, 1'b1);
        hot <= 1'b0;
        tick(LC - 1);
        chk("ot_pulse", line_oe, 1'b1);
        tick(4);
        chk("ot_pulse_end", line_oe, 1'b0);
        // Power-off and return
        poff <= 1'b1;
        tick(3);
        chk("poff_main", main_en, 1'b0);
        poff <= 1'b0;
        plen();
        chk("reexit_len", n, LC);
        rd(A_INTS);
        chk("pon_set", d[0], 1'b1);
        // Strap fitted gives short pulse
        {strap_fit, aresetn, pon} <= 3'b100;
        tick(5);
        aresetn <= 1'b1;
        tick(2);
        pon <= 1'b1;
        plen();
        chk("strap_len", n, SC);
        finish_test();
    end
endmodule
